// File: hw/csf_flag_cell.sv
// One latched flag: set by its cause, cleared by a read once the cause is gone.
// Assumes cause and read strobe are synchronous to mclk.
`timescale 1ns/1ps
module csf_flag_cell
  import csf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cause,
  input wire logic read_clr,
  output logic flag
);

  // Registered state and its next value
  csf_cell_s state;
  csf_cell_s next_state;

  // Set wins over clear; a read only clears once the cause has gone
  always_comb begin
    next_state = state;
    if (cause) begin
      next_state.flag = 1'b1;
    end else if (read_clr) begin
      next_state.flag = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      // Reset loads the constant value
      state.flag <= CSF_FLAG_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Flag output straight from the register
  assign flag = state.flag;

  // Read arriving while the cause is still active
  sequence s_read_with_cause;
    flag && read_clr && cause;
  endsequence

  // Read arriving after the cause has gone
  sequence s_read_cause_gone;
    flag && read_clr && !cause;
  endsequence

  a_flag_sets_cause: assert property (@(posedge mclk) disable iff (rst)
    cause |=> flag)
    else $error("flag not set after its cause");

  a_flag_held_read: assert property (@(posedge mclk) disable iff (rst)
    s_read_with_cause |=> flag)
    else $error("flag cleared while cause still present");

  a_flag_clear_read: assert property (@(posedge mclk) disable iff (rst)
    s_read_cause_gone |=> !flag)
    else $error("flag not cleared by read after recovery");

  a_flag_no_drop: assert property (@(posedge mclk) disable iff (rst)
    flag && !read_clr |=> flag)
    else $error("flag dropped without a read");

endmodule

// File: hw/csf_pkg.sv
// Shared constants and types for the CAN status and fault flag logic.
// Assumes one clock (mclk) and a synchronous active-high reset everywhere.
package csf_pkg;

  // Command word of the real-time status read (leaves live bits alone)
  localparam logic [15:0] CSF_STATUS_READ_CMD = 16'h2180;
  // Command word of the latched CAN flag read (clears eligible flags)
  localparam logic [15:0] CSF_FLAG_READ_CMD = 16'hDF00;
  // Number of latched flags held by the block
  localparam int CSF_NUM_FLAGS = 9;
  // Wake-up receiver enable after power-on
  localparam logic CSF_WAKE_RX_RESET = 1'b1;
  // Flag cell value after reset
  localparam logic CSF_FLAG_RESET = 1'b0;
  // Live bits after reset (wake receiver on, driver and receiver off)
  localparam logic [2:0] CSF_LIVE_RESET = 3'h4;

  // Operating mode of the CAN interface, one-hot
  typedef enum logic [2:0] {
    CSF_MODE_NORMAL = 3'h1,
    CSF_MODE_RX_ONLY = 3'h2,
    CSF_MODE_SLEEP = 3'h4
  } csf_mode_e;

  // Latched fault and event flags, can_wake in bit 0
  typedef struct packed {
    logic bus_fault_confirmed;
    logic bus_fault_unconfirmed;
    logic over_current;
    logic bus_dom_clamp;
    logic txd_dom;
    logic rxd_high;
    logic rxd_low;
    logic over_temp;
    logic can_wake;
  } csf_flags_s;

  // Real-time state bits
  typedef struct packed {
    logic bus_wake_receiver_on;
    logic receiver_on;
    logic driver_on;
  } csf_live_s;

  // Whole state of the top module
  typedef struct packed {
    csf_mode_e mode;
    logic wake_rx_cfg;
    csf_live_s live;
  } csf_state_s;

  // Whole state of one flag cell
  typedef struct packed {
    logic flag;
  } csf_cell_s;

endpackage

// File: hw/csf_status_flags.sv
// CAN transceiver status and fault flag logic: live state bits and latched flags.
// Assumes detector outputs and host command strobes are synchronous to mclk,
// and that commands arrive already decoded from the serial port as strobes.
`timescale 1ns/1ps

// Notes on behaviour
// - Driver state bit shows driver enabled
// - Driver off by mode command or failure
// - Status read leaves live bits unchanged
// - Receiver state bit shows receiver enabled
// - Host sleep command disables the receiver
// - Wake receiver bit, host-set, on after reset
// - Bus wake latches flag, read clears it
// - Over-temperature latched, clears after recovery and read
// - Receive pin low fault latched until read
// - Receive pin high fault latched until read
// - Transmit pin dominant fault latched until read
// - Bus dominant timeout clamp flag latched
// - Over-current flag latched until recovery and read
// - Unconfirmed bus failure flag at pre-detection
// - Confirmed bus failure flag at detection
module csf_status_flags
  import csf_pkg::*;
#(
  parameter int NUM_FLAGS = CSF_NUM_FLAGS
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode_wr,
  input wire csf_mode_e mode_in,
  input wire logic wake_cfg_wr,
  input wire logic wake_cfg_in,
  input wire logic rd_valid,
  input wire logic [15:0] rd_word,
  input wire logic can_wake_evt,
  input wire logic over_temp_det,
  input wire logic rxd_low_det,
  input wire logic rxd_high_det,
  input wire logic txd_dom_det,
  input wire logic bus_dom_clamp_det,
  input wire logic over_current_det,
  input wire logic bus_fault_pre_det,
  input wire logic bus_fault_det,
  output csf_live_s live,
  output csf_flags_s flags,
  output csf_mode_e mode
);

  // Registered state and its next value
  csf_state_s state;
  csf_state_s next_state;

  // Causes gathered in flag order
  csf_flags_s causes;
  // Latched flags as a plain vector
  logic [NUM_FLAGS-1:0] flag_vec;
  // Decoded strobe of a flag read
  logic flag_read;
  // Decoded strobe of a status read, used by checks only
  logic status_read;

  // Decode the two read command words
  assign flag_read = rd_valid && (rd_word == CSF_FLAG_READ_CMD);
  assign status_read = rd_valid && (rd_word == CSF_STATUS_READ_CMD);

  // Map each detector onto its flag
  always_comb begin
    causes = '0;
    causes.can_wake = can_wake_evt;
    causes.over_temp = over_temp_det;
    causes.rxd_low = rxd_low_det;
    causes.rxd_high = rxd_high_det;
    causes.txd_dom = txd_dom_det;
    causes.bus_dom_clamp = bus_dom_clamp_det;
    causes.over_current = over_current_det;
    causes.bus_fault_unconfirmed = bus_fault_pre_det;
    causes.bus_fault_confirmed = bus_fault_det;
  end

  // One flag cell per latched flag
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      csf_flag_cell u_cell (
        .mclk(mclk),
        .rst(rst),
        .cause(causes[gi]),
        .read_clr(flag_read),
        .flag(flag_vec[gi])
      );
    end
  endgenerate

  // Flags seen by the host
  assign flags = csf_flags_s'(flag_vec);

  // Next state: mode and wake configuration from the host, live bits follow
  always_comb begin
    next_state = state;
    // Mode command, illegal codes ignored
    if (mode_wr) begin
      case (mode_in)
        CSF_MODE_NORMAL: begin
          next_state.mode = CSF_MODE_NORMAL;
        end
        CSF_MODE_RX_ONLY: begin
          next_state.mode = CSF_MODE_RX_ONLY;
        end
        CSF_MODE_SLEEP: begin
          next_state.mode = CSF_MODE_SLEEP;
        end
        default: begin
          next_state.mode = state.mode;
        end
      endcase
    end
    // Wake-up receiver enable set by the host
    if (wake_cfg_wr) begin
      next_state.wake_rx_cfg = wake_cfg_in;
    end
    // Driver on only in normal mode with no transmit or thermal fault
    next_state.live.driver_on = (state.mode == CSF_MODE_NORMAL)
      && !flags.txd_dom && !flags.over_temp;
    // Receiver off only in sleep
    next_state.live.receiver_on = (state.mode != CSF_MODE_SLEEP);
    // Wake receiver mirrors its configuration bit
    next_state.live.bus_wake_receiver_on = state.wake_rx_cfg;
    // No read term enters the live bits
  end

  // State register, constants only under reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      state.mode <= CSF_MODE_NORMAL;
      state.wake_rx_cfg <= CSF_WAKE_RX_RESET;
      state.live <= csf_live_s'(CSF_LIVE_RESET);
    end else begin
      state <= next_state;
    end
  end

  // Outputs from registers
  assign live = state.live;
  assign mode = state.mode;

  // Driver disabled by a failure
  sequence s_txd_fault;
    txd_dom_det;
  endsequence

  // Mode other than normal
  sequence s_not_normal;
    (state.mode != CSF_MODE_NORMAL);
  endsequence

  a_drv_off_mode: assert property (@(posedge mclk) disable iff (rst)
    s_not_normal |=> !live.driver_on)
    else $error("driver on outside normal mode");

  a_drv_off_fault: assert property (@(posedge mclk) disable iff (rst)
    s_txd_fault |=> ##1 !live.driver_on)
    else $error("driver on after transmit dominant fault");

  a_drv_on_normal: assert property (@(posedge mclk) disable iff (rst)
    !rst && (state.mode == CSF_MODE_NORMAL) && !flags.txd_dom && !flags.over_temp |=> live.driver_on)
    else $error("driver off in fault-free normal mode");

  a_rcv_follows_sleep: assert property (@(posedge mclk) disable iff (rst)
    !rst |=> (live.receiver_on == ($past(state.mode) != CSF_MODE_SLEEP)))
    else $error("receiver bit disagrees with mode");

  a_sleep_cmd_rcv: assert property (@(posedge mclk) disable iff (rst)
    mode_wr && (mode_in == CSF_MODE_SLEEP) |=> ##1 !live.receiver_on)
    else $error("receiver still on after sleep command");

  a_wake_rx_default: assert property (@(posedge mclk)
    $fell(rst) |-> live.bus_wake_receiver_on)
    else $error("wake receiver not on after reset");

  a_wake_rx_cfg: assert property (@(posedge mclk) disable iff (rst)
    wake_cfg_wr |=> ##1 (live.bus_wake_receiver_on == $past(wake_cfg_in, 2)))
    else $error("wake receiver bit ignores configuration");

  a_status_read_live: assert property (@(posedge mclk) disable iff (rst)
    status_read && !mode_wr && !wake_cfg_wr && $stable(state) && $stable(flags) |=> $stable(live))
    else $error("status read changed live bits");

  a_status_read_flags: assert property (@(posedge mclk) disable iff (rst)
    status_read && (causes == '0) |=> (flags == $past(flags)))
    else $error("status read cleared a latched flag");

  a_wake_flag_clear: assert property (@(posedge mclk) disable iff (rst)
    flags.can_wake && flag_read && !can_wake_evt |=> !flags.can_wake)
    else $error("wake flag not cleared by flag read");

  a_temp_flag_held: assert property (@(posedge mclk) disable iff (rst)
    over_temp_det && flag_read |=> flags.over_temp)
    else $error("over-temperature flag cleared while hot");

  a_clamp_flag_set: assert property (@(posedge mclk) disable iff (rst)
    bus_dom_clamp_det |=> flags.bus_dom_clamp)
    else $error("clamp flag not set");

  a_bus_fail_set: assert property (@(posedge mclk) disable iff (rst)
    bus_fault_det |=> flags.bus_fault_confirmed)
    else $error("confirmed bus failure flag not set");

  a_rxd_low_set: assert property (@(posedge mclk) disable iff (rst)
    rxd_low_det |=> flags.rxd_low)
    else $error("receive pin low flag not set");

  a_rxd_high_set: assert property (@(posedge mclk) disable iff (rst)
    rxd_high_det |=> flags.rxd_high)
    else $error("receive pin high flag not set");

  a_txd_flag_set: assert property (@(posedge mclk) disable iff (rst)
    txd_dom_det |=> flags.txd_dom)
    else $error("transmit dominant flag not set");

  a_curr_flag_set: assert property (@(posedge mclk) disable iff (rst)
    over_current_det |=> flags.over_current)
    else $error("over-current flag not set");

  a_pre_fail_set: assert property (@(posedge mclk) disable iff (rst)
    bus_fault_pre_det |=> flags.bus_fault_unconfirmed)
    else $error("unconfirmed bus failure flag not set");

  a_mode_bad_code: assert property (@(posedge mclk) disable iff (rst)
    mode_wr && !(mode_in inside {CSF_MODE_NORMAL, CSF_MODE_RX_ONLY, CSF_MODE_SLEEP}) |=> $stable(mode))
    else $error("illegal mode code changed the mode");

endmodule

// File: tb/csf_host_model.sv
// Host-side model: issues mode, wake-config and read commands as strobes.
// Assumes commands start on a rising mclk edge and last one cycle.
`timescale 1ns/1ps
module csf_host_model
  import csf_pkg::*;
(
  input wire logic mclk,
  output logic mode_wr,
  output csf_mode_e mode_in,
  output logic wake_cfg_wr,
  output logic wake_cfg_in,
  output logic rd_valid,
  output logic [15:0] rd_word
);
  // Quiet command lines from time zero
  initial begin
    mode_wr = 1'b0;
    mode_in = CSF_MODE_NORMAL;
    wake_cfg_wr = 1'b0;
    wake_cfg_in = 1'b1;
    rd_valid = 1'b0;
    rd_word = 16'h0000;
  end

  // Mode command; sleep is how the host turns the receiver off
  task send_mode(input csf_mode_e m);
    @(posedge mclk);
    mode_wr <= 1'b1;
    mode_in <= m;
    @(posedge mclk);
    mode_wr <= 1'b0;
  endtask

  // Wake-up receiver enable command
  task send_wake(input logic en);
    @(posedge mclk);
    wake_cfg_wr <= 1'b1;
    wake_cfg_in <= en;
    @(posedge mclk);
    wake_cfg_wr <= 1'b0;
  endtask

  // Decoded read command word
  task send_read(input logic [15:0] w);
    @(posedge mclk);
    rd_valid <= 1'b1;
    rd_word <= w;
    @(posedge mclk);
    rd_valid <= 1'b0;
  endtask
endmodule

// File: tb/tb_csf_status_flags.sv
// Self-checking bench for the CAN status and fault flag logic.
// Assumes the host model drives commands; detectors are driven here.
`timescale 1ns/1ps
module tb_csf_status_flags;
  import csf_pkg::*;
  logic mclk;
  logic rst;
  logic [8:0] det; // Detector causes, bit order as the flags struct
  logic [8:0] exp; // Expected flag pattern
  logic mode_wr, wake_cfg_wr, wake_cfg_in, rd_valid;
  logic [15:0] rd_word;
  csf_mode_e mode_in, mode;
  csf_live_s live;
  csf_flags_s flags;
  int failures;
  int checked;

  csf_host_model host_u (.mclk(mclk), .mode_wr(mode_wr), .mode_in(mode_in), .wake_cfg_wr(wake_cfg_wr),
    .wake_cfg_in(wake_cfg_in), .rd_valid(rd_valid), .rd_word(rd_word));

  csf_status_flags dut_u (.mclk(mclk), .rst(rst), .mode_wr(mode_wr), .mode_in(mode_in),
    .wake_cfg_wr(wake_cfg_wr), .wake_cfg_in(wake_cfg_in), .rd_valid(rd_valid), .rd_word(rd_word),
    .can_wake_evt(det[0]), .over_temp_det(det[1]), .rxd_low_det(det[2]), .rxd_high_det(det[3]),
    .txd_dom_det(det[4]), .bus_dom_clamp_det(det[5]), .over_current_det(det[6]),
    .bus_fault_pre_det(det[7]), .bus_fault_det(det[8]), .live(live), .flags(flags), .mode(mode));

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Compare one value and count it
  task check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Wait n edges, then step past the edge so outputs are settled
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Counts, verdict and end of run
  task results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard: running out counts as a mismatch
  initial begin
    #200000;
    failures++;
    results();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    det = 9'h000;
    failures = 0;
    checked = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    tick(3);
    check("mode", 16'(mode), 16'(CSF_MODE_NORMAL));
    check("flags", 16'(flags), 16'h0000);
    check("live", 16'(live), 16'h0007);
    $display("test reset done");
    // Mode and wake commands drive the live driver, receiver and wake receiver bits
    host_u.send_mode(CSF_MODE_RX_ONLY);
    tick(2);
    check("live rx only", 16'(live), 16'h0006);
    host_u.send_mode(CSF_MODE_SLEEP);
    tick(2);
    check("live sleep", 16'(live), 16'h0004);
    host_u.send_mode(CSF_MODE_NORMAL);
    tick(2);
    check("live normal", 16'(live), 16'h0007);
    host_u.send_wake(1'b0);
    tick(2);
    check("live wake off", 16'(live), 16'h0003);
    host_u.send_wake(1'b1);
    tick(2);
    check("live wake on", 16'(live), 16'h0007);
    host_u.send_mode(csf_mode_e'(3'h3));
    tick(2);
    check("mode bad code", 16'(mode), 16'(CSF_MODE_NORMAL));
    check("live bad code", 16'(live), 16'h0007);
    $display("test modes done");
    // Each latched flag: set, survive reads while cause stays, clear after recovery
    for (int i = 0; i < 9; i++) begin
      exp = 9'h001 << i;
      @(posedge mclk);
      det <= exp;
      tick(2);
      check("flag set", 16'(flags), 16'(exp));
      host_u.send_read(CSF_STATUS_READ_CMD);
      tick(1);
      check("flag status read", 16'(flags), 16'(exp));
      check("live status read", 16'(live), (i == 1 || i == 4) ? 16'h0006 : 16'h0007);
      host_u.send_read(CSF_FLAG_READ_CMD);
      tick(1);
      check("flag read cause on", 16'(flags), 16'(exp));
      @(posedge mclk);
      det <= 9'h000;
      tick(2);
      check("flag held unread", 16'(flags), 16'(exp));
      host_u.send_read(CSF_FLAG_READ_CMD);
      tick(2);
      check("flag cleared", 16'(flags), 16'h0000);
      check("live restored", 16'(live), 16'h0007);
    end
    $display("test flags done");
    results();
  end
endmodule
